//--- dps_defines.vh
// Constants for the dual pot serial command slave.
// Assumes a 100 MHz core clock; included by the slave and the bench.
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
`define DPS_CLK_MHZ 100
`define DPS_NV_WRITE_MS 5
`define DPS_NV_MAX_MS 10
`define DPS_NV_CYCLES (`DPS_NV_WRITE_MS * 1000 * `DPS_CLK_MHZ)
// Device type code is arbitrary, picked for this block
`define DPS_TYPE_CODE 4'hA
`define DPS_OP_RD_WIPER 4'h9
`define DPS_OP_WR_WIPER 4'hA
`define DPS_OP_RD_SET 4'hB
`define DPS_OP_WR_SET 4'hC
`define DPS_OP_XFR_TO_WIPER 4'hD
`define DPS_OP_XFR_TO_SET 4'hE
`define DPS_OP_GXFR_TO_WIPER 4'h1
`define DPS_OP_GXFR_TO_SET 4'h8
`define DPS_OP_STEP 4'h2
`define DPS_WIPER_MAX 8'hFF
`define DPS_WIPER_MIN 8'h00
`define DPS_BIT_LAST 3'h7
`define DPS_BIT_FIRST 3'h0
`define DPS_CNT_W 20
`endif

//--- dps_tap_decoder.v
// One-hot tap switch decoder for one potentiometer.
// Assumes the wiper position comes from a register on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dps_tap_decoder (
  // Clock and reset
  input wire CLOCK,
  input wire RESET,
  // Wiper position in, tap enables out
  input wire [7:0] POSITION,
  output reg [255:0] TAPS
);
  // Registered so exactly one bit is ever set, never a glitchy overlap
  always @(posedge CLOCK) begin
    if (RESET) begin
      TAPS <= 256'h1;
    end else begin
      TAPS <= 256'h1 << POSITION; // see R02 see R03
    end
  end
endmodule // dps_tap_decoder
`default_nettype wire

//--- dps_serial_slave.v
// Two-wire command slave for a dual digital potentiometer.
// Assumes SCL/SDA arrive asynchronously and are sampled by CLOCK.
`timescale 1ns/1ns
`default_nettype none
`include "dps_defines.vh"
// Overview of operation
// (R01) Write-protect low refuses every nonvolatile setting write.
// (R02) Wiper position decodes to one-hot choice of 256 taps.
// (R03) Never more than one tap switch enabled per pot.
// (R04) Data changes only while clock low; high-clock changes mean start/stop.
// (R05) Start is data falling with clock high; ignore bus until then.
// (R06) Master ends each transaction with data rising with clock high.
// (R07) Transmitter releases data after eight bits; receiver acks on ninth.
// (R08) Ack matching address, command byte, and following data byte.
// (R09) Stop after nonvolatile write starts write cycle; address unacked meanwhile.
// (R10) Upper nibble of first byte must equal own type code.
// (R11) Lower nibble of first byte must match four strap pins.
// (R12) Instruction: opcode nibble, two setting selects, zero, pot select.
// (R13) Setting select bits pick register zero to three in binary.
// (R14) Opcode 1001 returns selected wiper position.
// (R15) Opcode 1010 loads next data byte into selected wiper position.
// (R16) Opcode 1011 returns selected setting register.
// (R17) Opcode 1100 writes next data byte into selected setting register.
// (R18) Opcode 1101 copies selected setting register into wiper position.
// (R19) Opcode 1110 copies wiper position into selected setting register.
// (R20) Opcode 0001, pot select zero, loads every wiper from its setting.
// (R21) Opcode 1000, pot select zero, stores every wiper into setting.
// (R22) Opcode 0010 enters step mode for selected wiper.
// (R23) Step: clock pulse with data high up, data low down.
// (R24) At power-up, setting register zero loads each wiper.
// (R25) Nonvolatile changes complete within ten milliseconds.
// (R26) Sample data on rising clock, present bits after falling clock.
// (R27) Stepping saturates at 0 and 255.
// (R28) Unknown opcodes are ignored, no register changed.
module dps_serial_slave #(
  parameter NV_CYCLES = `DPS_NV_CYCLES
) (
  // Clock and reset
  input wire CLOCK,
  input wire RESET,
  // Two-wire bus
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // Straps and protection
  input wire [3:0] ADDR_STRAP_PINS,
  input wire WRITE_PROTECT_N,
  // Status and tap enables
  output reg NV_BUSY,
  output wire [255:0] TAPS0,
  output wire [255:0] TAPS1
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_STEP = 3'h5;
  localparam ST_WAIT = 3'h6;

  reg scl_meta_reg, scl_sync_reg, scl_prev_reg;
  reg sda_meta_reg, sda_sync_reg, sda_prev_reg;
  reg wp_meta_reg, wp_sync_reg;
  reg [3:0] strap_meta_reg;
  reg [3:0] strap_sync_reg;
  // Step direction is held from the rise to the end of the pulse
  reg step_arm_reg;
  reg step_up_reg;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg ack_phase_reg;
  reg [7:0] shift_reg;
  reg [7:0] cmd_reg;
  reg [7:0] wiper_position_reg [0:1];
  reg [7:0] nv_setting_reg [0:7];
  reg [`DPS_CNT_W-1:0] nv_cnt_reg;
  reg [7:0] nv_data_reg [0:1];
  reg [2:0] nv_idx_reg [0:1];
  reg [1:0] nv_pend_reg;
  reg [1:0] nv_arm_reg;
  reg boot_reg;
  integer i;

  wire scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg & scl_prev_reg;
  wire start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg &
    ~sda_sync_reg; // see R05 see R04
  wire stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
    sda_sync_reg; // see R06 see R04
  wire [3:0] opcode = cmd_reg[7:4]; // see R12
  wire pot_select = cmd_reg[0];
  wire setting_sel_hi = cmd_reg[3];
  wire setting_sel_lo = cmd_reg[2];
  wire [1:0] setting_sel = {setting_sel_hi, setting_sel_lo}; // see R13
  wire [2:0] sel_idx = {pot_select, setting_sel};
  wire [7:0] shifted = {shift_reg[6:0], sda_sync_reg};
  wire [7:0] wiper_sel = wiper_position_reg[pot_select];
  wire addr_match = (shifted[7:4] == `DPS_TYPE_CODE) && // see R10
    (shifted[3:0] == strap_sync_reg); // see R11
  wire wp_ok = wp_sync_reg; // see R01

  // Two-flop input synchronisers
  always @(posedge CLOCK) begin
    if (RESET) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      // Protected until the pin has actually been sampled
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end else begin
      scl_meta_reg <= SCL_IN;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= SDA_IN;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      // Straps and write protect are pins too
      wp_meta_reg <= WRITE_PROTECT_N;
      wp_sync_reg <= wp_meta_reg;
      strap_meta_reg <= ADDR_STRAP_PINS;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Protocol engine
  always @(posedge CLOCK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      ack_phase_reg <= 1'b0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      SDA_OUT <= 1'b1;
      SDA_OE <= 1'b0;
      NV_BUSY <= 1'b0;
      nv_cnt_reg <= {`DPS_CNT_W{1'b0}};
      nv_pend_reg <= 2'h0;
      nv_arm_reg <= 2'h0;
      boot_reg <= 1'b1;
      step_arm_reg <= 1'b0;
      step_up_reg <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        wiper_position_reg[i] <= 8'h00;
        nv_data_reg[i] <= 8'h00;
        nv_idx_reg[i] <= 3'h0;
      end
      for (i = 0; i < 8; i = i + 1) begin
        nv_setting_reg[i] <= 8'h00;
      end
    end else if (boot_reg) begin
      // Power-up recall of setting register zero per pot
      boot_reg <= 1'b0;
      wiper_position_reg[0] <= nv_setting_reg[0]; // see R24
      wiper_position_reg[1] <= nv_setting_reg[4]; // see R24
    end else begin
      // Internal nonvolatile write timer
      if (NV_BUSY) begin
        if (nv_cnt_reg == NV_CYCLES[`DPS_CNT_W-1:0] - 1'b1) begin
          NV_BUSY <= 1'b0; // see R25
          nv_cnt_reg <= {`DPS_CNT_W{1'b0}};
          for (i = 0; i < 2; i = i + 1) begin
            if (nv_pend_reg[i]) begin
              nv_setting_reg[nv_idx_reg[i]] <= nv_data_reg[i];
            end
          end
          nv_pend_reg <= 2'h0;
        end else begin
          nv_cnt_reg <= nv_cnt_reg + 1'b1;
        end
      end
      if (stop_det) begin
        // Armed nonvolatile write is launched only by the stop
        if (nv_arm_reg != 2'h0 && wp_ok) begin
          NV_BUSY <= 1'b1; // see R09
          nv_pend_reg <= nv_arm_reg;
          nv_cnt_reg <= {`DPS_CNT_W{1'b0}};
        end
        nv_arm_reg <= 2'h0;
        // A rise that the stop cut short must never step the wiper
        step_arm_reg <= 1'b0;
        state_reg <= ST_IDLE;
        SDA_OE <= 1'b0;
        SDA_OUT <= 1'b1;
      end else if (start_det) begin
        // Repeated start drops any armed write
        nv_arm_reg <= 2'h0;
        state_reg <= ST_ADDR;
        step_arm_reg <= 1'b0;
        bit_cnt_reg <= 3'h0;
        ack_phase_reg <= 1'b0;
        SDA_OE <= 1'b0;
        SDA_OUT <= 1'b1;
      end else if (state_reg == ST_STEP && !ack_phase_reg) begin
        // Direction taken at the rise, applied when the pulse ends, so
        // the clock high phase of a closing stop never moves the wiper
        if (scl_rise) begin
          step_arm_reg <= 1'b1; // see R26
          step_up_reg <= sda_sync_reg; // see R23
        end else if (scl_fall && step_arm_reg) begin
          step_arm_reg <= 1'b0;
          if (step_up_reg) begin // see R23
            if (wiper_sel != `DPS_WIPER_MAX) begin
              wiper_position_reg[pot_select] <= wiper_sel + 1'b1; // see R27
            end
          end else if (wiper_sel != `DPS_WIPER_MIN) begin
            wiper_position_reg[pot_select] <= wiper_sel - 1'b1; // see R27
          end
        end
      end else if (state_reg != ST_IDLE && scl_fall) begin
        // Drive or release after each falling edge
        if (ack_phase_reg && !SDA_OE) begin
          // Byte taken: pull low for the whole ninth clock
          SDA_OE <= 1'b1; // see R07
          SDA_OUT <= 1'b0;
        end else if (ack_phase_reg) begin
          // Ninth clock over: let go, or put out the first read bit
          ack_phase_reg <= 1'b0;
          SDA_OE <= 1'b0;
          SDA_OUT <= 1'b1;
          if (state_reg == ST_SEND) begin
            SDA_OE <= 1'b1; // see R26
            SDA_OUT <= shift_reg[7];
          end
        end else if (state_reg == ST_SEND && SDA_OE) begin
          if (bit_cnt_reg == `DPS_BIT_FIRST) begin
            // Eight bits out: release so the master can answer
            SDA_OE <= 1'b0; // see R07
            SDA_OUT <= 1'b1;
          end else begin
            SDA_OUT <= shift_reg[7]; // see R26
          end
        end
      end else if (state_reg != ST_IDLE && scl_rise && !ack_phase_reg) begin
        // The ninth clock carries no data, so it is not shifted in
        case (state_reg)
          ST_SEND: begin
            if (SDA_OE) begin
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
              shift_reg <= {shift_reg[6:0], 1'b0};
            end else begin
              // Master ack or nack; one byte only, then wait for stop
              state_reg <= ST_WAIT;
            end
          end
          ST_ADDR, ST_CMD, ST_DATA: begin
            shift_reg <= shifted; // see R26
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == `DPS_BIT_LAST) begin
              state_reg <= ST_WAIT;
              if (state_reg == ST_ADDR) begin
                if (addr_match && !NV_BUSY) begin // see R09
                  state_reg <= ST_CMD;
                  ack_phase_reg <= 1'b1; // see R08
                end
              end else if (state_reg == ST_CMD) begin
                cmd_reg <= shifted;
                ack_phase_reg <= 1'b1; // see R08
                case (shifted[7:4])
                  `DPS_OP_RD_WIPER: begin
                    state_reg <= ST_SEND; // see R14
                    shift_reg <= wiper_position_reg[shifted[0]];
                  end
                  `DPS_OP_RD_SET: begin
                    state_reg <= ST_SEND; // see R16
                    shift_reg <= nv_setting_reg[{shifted[0], shifted[3:2]}];
                  end
                  `DPS_OP_WR_WIPER, `DPS_OP_WR_SET: begin
                    state_reg <= ST_DATA;
                  end
                  `DPS_OP_XFR_TO_WIPER: begin
                    wiper_position_reg[shifted[0]] <=
                      nv_setting_reg[{shifted[0], shifted[3:2]}]; // see R18
                  end
                  `DPS_OP_XFR_TO_SET: begin
                    nv_data_reg[shifted[0]] <= wiper_position_reg[shifted[0]];
                    nv_idx_reg[shifted[0]] <= {shifted[0], shifted[3:2]};
                    nv_arm_reg[shifted[0]] <= 1'b1; // see R19
                  end
                  `DPS_OP_GXFR_TO_WIPER: begin
                    if (!shifted[0]) begin // see R20
                      wiper_position_reg[0] <=
                        nv_setting_reg[{1'b0, shifted[3:2]}];
                      wiper_position_reg[1] <=
                        nv_setting_reg[{1'b1, shifted[3:2]}];
                    end
                  end
                  `DPS_OP_GXFR_TO_SET: begin
                    if (!shifted[0]) begin // see R21
                      for (i = 0; i < 2; i = i + 1) begin
                        nv_data_reg[i] <= wiper_position_reg[i];
                      end
                      nv_idx_reg[0] <= {1'b0, shifted[3:2]};
                      nv_idx_reg[1] <= {1'b1, shifted[3:2]};
                      nv_arm_reg <= 2'h3;
                    end
                  end
                  `DPS_OP_STEP: begin
                    state_reg <= ST_STEP; // see R22
                  end
                  default: begin
                    state_reg <= ST_WAIT; // see R28
                  end
                endcase
              end else begin
                ack_phase_reg <= 1'b1; // see R08
                if (opcode == `DPS_OP_WR_WIPER) begin
                  wiper_position_reg[pot_select] <= shifted; // see R15
                end else begin
                  nv_data_reg[pot_select] <= shifted; // see R17
                  nv_idx_reg[pot_select] <= sel_idx;
                  nv_arm_reg[pot_select] <= 1'b1;
                end
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Tap switch decoders
  dps_tap_decoder u_taps0 (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .POSITION(wiper_position_reg[0]),
    .TAPS(TAPS0)
  ); // see R02
  dps_tap_decoder u_taps1 (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .POSITION(wiper_position_reg[1]),
    .TAPS(TAPS1)
  ); // see R02
endmodule // dps_serial_slave
`default_nettype wire

//--- dps_props.sv
// Port checks for the dual pot serial command slave.
// Assumes it is bound to dps_serial_slave and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module dps_props #(
  parameter NV_CYCLES = 50
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // Straps and protection
  input wire logic [3:0] ADDR_STRAP_PINS,
  input wire logic WRITE_PROTECT_N,
  // Status and taps
  input wire logic NV_BUSY,
  input wire logic [255:0] TAPS0,
  input wire logic [255:0] TAPS1
);
  int busy_cnt;
  wire pull_low = SDA_OE && !SDA_OUT;
  always @(posedge CLOCK) begin
    if (RESET || !NV_BUSY) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  taps0_onehot_a: assert property ($onehot(TAPS0))
    else $error("pot 0 tap enables not one-hot");
  taps1_onehot_a: assert property ($onehot(TAPS1))
    else $error("pot 1 tap enables not one-hot");
  busy_len_a: assert property (
    $fell(NV_BUSY) |-> busy_cnt inside {[NV_CYCLES-1:NV_CYCLES+1]})
    else $error("write cycle length wrong");
  busy_quiet_a: assert property (
    NV_BUSY && $past(NV_BUSY) |-> !SDA_OE)
    else $error("bus driven during write cycle");
  busy_hold_a: assert property (
    NV_BUSY && $past(NV_BUSY) |-> $stable(TAPS0) && $stable(TAPS1))
    else $error("wiper moved during write cycle");
  sda_scl_low_a: assert property (
    $changed(pull_low) |-> !SCL_IN)
    else $error("data changed with clock high");
  ack_stands_a: assert property (
    $rose(pull_low) |-> pull_low [*8])
    else $error("driven low bit too short");
  reset_idle_a: assert property (
    disable iff (1'b0) RESET |=> !SDA_OE && !NV_BUSY)
    else $error("outputs busy after reset");
endmodule // dps_props
`default_nettype wire

//--- dps_master_model.sv
// Two-wire bus master model driving the serial clock.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module dps_master_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_wire,
  output var logic scl,
  output var logic sda_drv
);
  logic odd = 1'b0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves two cycles into the low phase, after the slave saw the fall
  task automatic bit_x(input logic b, output logic r);
    w(2);
    sda_drv <= b;
    // Low phase alternates 6 and 7 cycles: a 125 ns clock on average
    w(4);
    if (odd) w(1);
    odd = !odd;
    scl <= 1'b1;
    w(4);
    r = sda_wire;
    w(2);
    scl <= 1'b0;
  endtask
  task automatic start;
    sda_drv <= 1'b1;
    w(3);
    scl <= 1'b1;
    w(5);
    sda_drv <= 1'b0;
    w(5);
    scl <= 1'b0;
  endtask
  task automatic stop;
    w(5);
    sda_drv <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(5);
    sda_drv <= 1'b1;
    w(5);
  endtask
  task automatic tx(input logic [7:0] d, output logic [7:0] q,
      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask
endmodule // dps_master_model
`default_nettype wire

//--- dps_tb.sv
// Self-checking bench for the dual pot serial command slave.
// Assumes the master model and checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "dps_defines.vh"
module testbench;
  localparam int NV = 400;
  localparam logic [3:0] STRAP = 4'h6;
  localparam logic [7:0] ID = {`DPS_TYPE_CODE, STRAP};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  logic [3:0] strap = STRAP;
  wire scl;
  wire sda_drv;
  wire sda_out;
  wire sda_oe;
  wire nv_busy;
  wire [255:0] taps0;
  wire [255:0] taps1;
  wire sda = sda_drv & ~(sda_oe & ~sda_out);
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] rd;
  logic [2:0] ak;
  always #5 clock = ~clock;
  dps_master_model master (.clk(clock), .sda_wire(sda), .scl(scl),
    .sda_drv(sda_drv));
  dps_serial_slave #(.NV_CYCLES(NV)) i_dps_serial_slave (.CLOCK(clock),
    .RESET(reset), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .ADDR_STRAP_PINS(strap), .WRITE_PROTECT_N(wp_n),
    .NV_BUSY(nv_busy), .TAPS0(taps0), .TAPS1(taps1));
  task automatic check(input string what, input logic [255:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] ins(input logic [3:0] op,
      input logic [1:0] sel, input logic pot);
    return {op, sel, 1'b0, pot};
  endfunction
  // Kind: 0 address, 1 two-byte, 2 write, 3 read, 4 left open
  task automatic cmd(input logic [7:0] id, op, dat, input int kind,
      output logic [2:0] a);
    logic [7:0] q;
    a = 3'h0;
    master.start();
    master.tx(id, q, a[2]);
    if (kind > 0) master.tx(op, q, a[1]);
    if (kind == 2) master.tx(dat, q, a[0]);
    if (kind == 3) master.tx(8'hFF, rd, q[0]);
    if (kind != 4) master.stop();
  endtask
  task automatic rd_chk(input logic [7:0] op, e);
    cmd(ID, op, 8'h00, 3, ak);
    check("read byte", rd, e);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < NV + 50 && nv_busy === 1'b1; i++)
      @(posedge clock);
    check("busy end", nv_busy, 1'b0);
  endtask
  task automatic step(input logic pot, up, input int n, input [7:0] e);
    logic r;
    cmd(ID, ins(`DPS_OP_STEP, 2'b00, pot), 8'h00, 4, ak);
    repeat (n) master.bit_x(up, r);
    repeat (6) @(posedge clock);
    check("step", pot ? taps1 : taps0, 256'h1 << e);
    master.stop();
    check("step kept", pot ? taps1 : taps0, 256'h1 << e);
  endtask
  task automatic t_basic;
    logic [7:0] bad [2] = '{{`DPS_TYPE_CODE, STRAP ^ 4'h1}, {4'h3, STRAP}};
    check("recall", taps0, 256'h1);
    cmd(ID, ins(`DPS_OP_WR_WIPER, 2'b00, 1'b0), 8'h5A, 2, ak);
    check("acks", ak, 3'h7);
    check("taps0", taps0, 256'h1 << 8'h5A);
    check("taps1", taps1, 256'h1);
    rd_chk(ins(`DPS_OP_RD_WIPER, 2'b00, 1'b0), 8'h5A);
    foreach (bad[i]) begin
      cmd(bad[i], ins(`DPS_OP_WR_WIPER, 2'b00, 1'b0), 8'h11, 2, ak);
      check("refused", ak, 3'h0);
    end
    check("taps0 kept", taps0, 256'h1 << 8'h5A);
    $display("test basic done");
  endtask
  task automatic t_nv;
    cmd(ID, ins(`DPS_OP_WR_SET, 2'b10, 1'b1), 8'h3C, 2, ak);
    check("busy", nv_busy, 1'b1);
    cmd(ID, 8'h00, 8'h00, 0, ak);
    check("poll", ak, 3'h0);
    wait_idle();
    rd_chk(ins(`DPS_OP_RD_SET, 2'b10, 1'b1), 8'h3C);
    rd_chk(ins(`DPS_OP_RD_SET, 2'b01, 1'b1), 8'h00);
    wp_n <= 1'b0;
    cmd(ID, ins(`DPS_OP_WR_SET, 2'b10, 1'b1), 8'h77, 2, ak);
    wait_idle();
    wp_n <= 1'b1;
    rd_chk(ins(`DPS_OP_RD_SET, 2'b10, 1'b1), 8'h3C);
    $display("test nv done");
  endtask
  task automatic t_xfer;
    cmd(ID, ins(`DPS_OP_XFR_TO_WIPER, 2'b10, 1'b1), 8'h00, 1, ak);
    check("xfr", taps1, 256'h1 << 8'h3C);
    cmd(ID, ins(`DPS_OP_XFR_TO_SET, 2'b01, 1'b0), 8'h00, 1, ak);
    wait_idle();
    cmd(ID, ins(`DPS_OP_GXFR_TO_SET, 2'b11, 1'b0), 8'h00, 1, ak);
    wait_idle();
    cmd(ID, ins(`DPS_OP_GXFR_TO_WIPER, 2'b01, 1'b0), 8'h00, 1, ak);
    check("gxfr", taps1, 256'h1);
    rd_chk(ins(`DPS_OP_RD_SET, 2'b01, 1'b0), 8'h5A);
    rd_chk(ins(`DPS_OP_RD_SET, 2'b11, 1'b1), 8'h3C);
    cmd(ID, 8'h30, 8'h00, 1, ak);
    check("odd op ack", ak, 3'h6);
    check("odd op", taps0, 256'h1 << 8'h5A);
    $display("test transfer done");
  endtask
  task automatic t_step;
    step(1'b0, 1'b1, 3, 8'h5D);
    step(1'b1, 1'b0, 2, 8'h00);
    cmd(ID, ins(`DPS_OP_WR_WIPER, 2'b00, 1'b1), 8'hFE, 2, ak);
    step(1'b1, 1'b1, 3, 8'hFF);
    $display("test step done");
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    t_basic();
    t_nv();
    t_xfer();
    t_step();
    stop_test();
  end
endmodule // testbench
bind dps_serial_slave dps_props #(.NV_CYCLES(NV_CYCLES)) i_dps_props (
  .CLOCK, .RESET, .SCL_IN, .SDA_IN, .SDA_OUT, .SDA_OE, .ADDR_STRAP_PINS,
  .WRITE_PROTECT_N, .NV_BUSY, .TAPS0, .TAPS1);
`default_nettype wire
